//--- verilog/dual_capture_compare.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ccp_defines.svh"

module dual_capture_compare (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // channel pins
    input wire logic [1:0] CH_PIN_I,
    output logic [1:0] CH_PIN_O,
    output logic [1:0] CH_PIN_OE_O,
    // interrupt request
    output logic IRQ_O
);

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    ccp_pkg::apb_req_t req;
    logic [7:0] idx;
    logic mapped;
    logic access;
    logic wr_stb;
    logic [7:0] wbyte;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [7:0] rd_byte;
    assign req.sel = PSEL_I;
    assign req.enable = PENABLE_I;
    assign req.write = PWRITE_I;
    assign req.addr = PADDR_I;
    assign req.wdata = PWDATA_I;
    assign idx = req.addr[9:2];
    assign wbyte = req.wdata[7:0];
    // a write lands on the single edge where pready is seen high
    assign access = req.sel && req.enable && pready_r;
    assign wr_stb = access && req.write && mapped;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] global_r;
    logic [7:0] irq_en_r;
    logic [7:0] flags_r;
    logic [7:0] cnt_ctrl_r;
    logic [15:0] counter_r;
    logic [7:0] mode_r;
    logic [1:0][15:0] chan_val_w;
    logic [1:0] chan_event_w;
    logic [1:0] chan_clr_w;
    logic [1:0] chan_pin_w;
    logic [1:0] chan_oe_w;
    logic mode_wr;
    logic cnt_run;
    logic cnt_wide;
    assign mode_wr = wr_stb && (idx == `CCP_IDX_MODE);
    assign cnt_run = cnt_ctrl_r[`CCP_BIT_RUN];
    assign cnt_wide = cnt_ctrl_r[`CCP_BIT_WIDE];

    always_comb begin
        mapped = 1'b0;
        if (req.addr[11:10] == 2'b00 && req.addr[1:0] == 2'b00) begin
            case (idx)
                `CCP_IDX_GLOBAL,
                `CCP_IDX_IRQ_EN,
                `CCP_IDX_FLAGS,
                `CCP_IDX_CNT_CTRL,
                `CCP_IDX_CNT_HI,
                `CCP_IDX_CNT_LO,
                `CCP_IDX_MODE,
                `CCP_IDX_CH0_HI,
                `CCP_IDX_CH0_LO,
                `CCP_IDX_CH1_HI,
                `CCP_IDX_CH1_LO: begin
                    mapped = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        case (idx)
            `CCP_IDX_GLOBAL: rd_byte = global_r;
            `CCP_IDX_IRQ_EN: rd_byte = irq_en_r;
            `CCP_IDX_FLAGS: rd_byte = flags_r;
            `CCP_IDX_CNT_CTRL: rd_byte = cnt_ctrl_r;
            `CCP_IDX_CNT_HI: rd_byte = counter_r[15:8];
            `CCP_IDX_CNT_LO: rd_byte = counter_r[7:0];
            `CCP_IDX_MODE: rd_byte = mode_r;
            `CCP_IDX_CH0_HI: rd_byte = chan_val_w[0][15:8];
            `CCP_IDX_CH0_LO: rd_byte = chan_val_w[0][7:0];
            `CCP_IDX_CH1_HI: rd_byte = chan_val_w[1][15:8];
            `CCP_IDX_CH1_LO: rd_byte = chan_val_w[1][7:0];
            default: rd_byte = `CCP_RST_BYTE;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (req.sel && req.enable && !pready_r) begin
            pready_r <= 1'b1;
            prdata_r <= (!req.write && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_r <= !mapped;
        end else begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end
    assign PREADY_O = pready_r;
    assign PRDATA_O = prdata_r;
    assign PSLVERR_O = pslverr_r;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            global_r <= `CCP_RST_BYTE;
        end else if (wr_stb && idx == `CCP_IDX_GLOBAL) begin
            global_r <= wbyte & 8'h80;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            irq_en_r <= `CCP_RST_BYTE;
        end else if (wr_stb && idx == `CCP_IDX_IRQ_EN) begin
            irq_en_r <= wbyte & `CCP_CHAN_MASK;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            flags_r <= `CCP_RST_BYTE;
        end else if (wr_stb && idx == `CCP_IDX_FLAGS) begin
            flags_r <= (wbyte & `CCP_CHAN_MASK) | {6'b00_0000, chan_event_w};
        end else begin
            flags_r <= flags_r | {6'b00_0000, chan_event_w};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cnt_ctrl_r <= `CCP_RST_BYTE;
        end else if (wr_stb && idx == `CCP_IDX_CNT_CTRL) begin
            cnt_ctrl_r <= wbyte & `CCP_CTRL_MASK;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mode_r <= `CCP_RST_BYTE;
        end else if (mode_wr) begin
            mode_r <= wbyte;
        end
    end

    assign IRQ_O = global_r[`CCP_BIT_GIE] && |(flags_r[1:0] & irq_en_r[1:0]);

    // ------------------------------------------------------------
    // shared counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            counter_r <= `CCP_RST_WORD;
        end else if (!cnt_run) begin
            counter_r <= `CCP_RST_WORD;
        end else if (|chan_clr_w) begin
            counter_r <= `CCP_RST_WORD;
        end else if (wr_stb && idx == `CCP_IDX_CNT_HI) begin
            counter_r <= {wbyte, counter_r[7:0]};
        end else if (wr_stb && idx == `CCP_IDX_CNT_LO) begin
            counter_r <= {counter_r[15:8], wbyte};
        end else if (cnt_wide) begin
            counter_r <= counter_r + 16'h0001;
        end else begin
            // narrow mode wraps in the low byte
            counter_r <= {8'h00, counter_r[7:0] + 8'h01};
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        ccp_pkg::chan_mode_t mode;
        logic [7:0] idx_hi;
        logic [7:0] idx_lo;
        logic is_cap;
        logic is_cmp;
        logic sync1_r;
        logic sync2_r;
        logic sync3_r;
        logic level_r;
        logic settled;
        logic rise;
        logic fall;
        logic [3:0] edge_cnt_r;
        logic cap_hit;
        logic match;
        logic match_d_r;
        logic cmp_hit;
        logic [15:0] val_r;
        logic pin_r;
        assign mode = ccp_pkg::chan_mode_t'(mode_r[4 * ch +: 4]);
        assign idx_hi = (ch == 0) ? `CCP_IDX_CH0_HI : `CCP_IDX_CH1_HI;
        assign idx_lo = (ch == 0) ? `CCP_IDX_CH0_LO : `CCP_IDX_CH1_LO;
        // at most one of the two is ever true for a code; neither for MODE_OFF or unused codes
        always_comb begin
            is_cap = 1'b0;
            is_cmp = 1'b0;
            case (mode)
                ccp_pkg::MODE_CAP_FALL,
                ccp_pkg::MODE_CAP_RISE,
                ccp_pkg::MODE_CAP_RISE4,
                ccp_pkg::MODE_CAP_RISE16: is_cap = 1'b1;
                ccp_pkg::MODE_CMP_TOGGLE,
                ccp_pkg::MODE_CMP_SET_HIGH,
                ccp_pkg::MODE_CMP_SET_LOW,
                ccp_pkg::MODE_CMP_FLAG,
                ccp_pkg::MODE_CMP_CLEAR: is_cmp = 1'b1;
                default: begin
                    is_cap = 1'b0;
                    is_cmp = 1'b0;
                end
            endcase
        end

        // three stages; level accepted only once stages two and three agree
        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                sync1_r <= 1'b0;
                sync2_r <= 1'b0;
                sync3_r <= 1'b0;
            end else begin
                sync1_r <= CH_PIN_I[ch];
                sync2_r <= sync1_r;
                sync3_r <= sync2_r;
            end
        end
        assign settled = (sync2_r == sync3_r);
        assign rise = settled && sync3_r && !level_r;
        assign fall = settled && !sync3_r && level_r;
        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                level_r <= 1'b0;
            end else if (settled) begin
                level_r <= sync3_r;
            end
        end

        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                edge_cnt_r <= 4'h0;
            end else if (mode_wr) begin
                edge_cnt_r <= 4'h0;
            end else if (is_cap && rise) begin
                edge_cnt_r <= edge_cnt_r + 4'h1;
            end
        end

        always_comb begin
            case (mode)
                ccp_pkg::MODE_CAP_FALL: cap_hit = fall;
                ccp_pkg::MODE_CAP_RISE: cap_hit = rise;
                ccp_pkg::MODE_CAP_RISE4:
                    cap_hit = rise && edge_cnt_r[1:0] == 2'(`CCP_EDGES_4_LAST);
                ccp_pkg::MODE_CAP_RISE16:
                    cap_hit = rise && edge_cnt_r == `CCP_EDGES_16_LAST;
                default: cap_hit = 1'b0;
            endcase
        end
        // equality is edge-detected so a halted counter flags only once
        assign match = is_cmp && (val_r == counter_r);
        assign cmp_hit = match && !match_d_r;
        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                match_d_r <= 1'b0;
            end else begin
                match_d_r <= match;
            end
        end

        // capture beats a software byte write in the same cycle
        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                val_r <= `CCP_RST_WORD;
            end else if (cap_hit) begin
                val_r <= counter_r;
            end else if (wr_stb && idx == idx_hi) begin
                val_r <= {wbyte, val_r[7:0]};
            end else if (wr_stb && idx == idx_lo) begin
                val_r <= {val_r[15:8], wbyte};
            end
        end

        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                pin_r <= 1'b0;
            end else if (mode_wr) begin
                case (wbyte[4 * ch +: 4])
                    ccp_pkg::MODE_CMP_SET_LOW: pin_r <= 1'b1;
                    ccp_pkg::MODE_CMP_SET_HIGH: pin_r <= 1'b0;
                    default: pin_r <= pin_r;
                endcase
            end else if (cmp_hit) begin
                case (mode)
                    ccp_pkg::MODE_CMP_SET_LOW: pin_r <= 1'b0;
                    ccp_pkg::MODE_CMP_SET_HIGH: pin_r <= 1'b1;
                    ccp_pkg::MODE_CMP_TOGGLE: pin_r <= !pin_r;
                    default: pin_r <= pin_r;
                endcase
            end
        end

        assign chan_val_w[ch] = val_r;
        assign chan_event_w[ch] = cap_hit || cmp_hit;
        assign chan_clr_w[ch] = cmp_hit && mode == ccp_pkg::MODE_CMP_CLEAR;
        assign chan_pin_w[ch] = pin_r;
        assign chan_oe_w[ch] = mode == ccp_pkg::MODE_CMP_SET_LOW
                            || mode == ccp_pkg::MODE_CMP_SET_HIGH
                            || mode == ccp_pkg::MODE_CMP_TOGGLE;
    end
    assign CH_PIN_O = chan_pin_w;
    assign CH_PIN_OE_O = chan_oe_w;
endmodule : dual_capture_compare

//--- common/ccp_defines.svh
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// register indices; byte address is four times the index
`define CCP_IDX_GLOBAL 8'h23
`define CCP_IDX_IRQ_EN 8'h24
`define CCP_IDX_FLAGS 8'h27
`define CCP_IDX_CNT_CTRL 8'h43
`define CCP_IDX_CNT_HI 8'h44
`define CCP_IDX_CNT_LO 8'h45
`define CCP_IDX_MODE 8'h49
`define CCP_IDX_CH0_HI 8'h4a
`define CCP_IDX_CH0_LO 8'h4b
`define CCP_IDX_CH1_HI 8'h4c
`define CCP_IDX_CH1_LO 8'h4d

// field positions
`define CCP_BIT_GIE 7
`define CCP_BIT_RUN 7
`define CCP_BIT_WIDE 2
`define CCP_CTRL_MASK 8'hfc
`define CCP_CHAN_MASK 8'h03

// reset values
`define CCP_RST_BYTE 8'h00
`define CCP_RST_WORD 16'h0000

// edge prescaler terminal counts
`define CCP_EDGES_4_LAST 4'h3
`define CCP_EDGES_16_LAST 4'hf

`endif

//--- common/ccp_pkg.sv
package ccp_pkg;

    typedef enum logic [3:0] {
        MODE_OFF = 4'b0000,
        MODE_UNUSED1 = 4'b0001,
        MODE_CMP_TOGGLE = 4'b0010,
        MODE_UNUSED3 = 4'b0011,
        MODE_CAP_FALL = 4'b0100,
        MODE_CAP_RISE = 4'b0101,
        MODE_CAP_RISE4 = 4'b0110,
        MODE_CAP_RISE16 = 4'b0111,
        MODE_CMP_SET_HIGH = 4'b1000,
        MODE_CMP_SET_LOW = 4'b1001,
        MODE_CMP_FLAG = 4'b1010,
        MODE_CMP_CLEAR = 4'b1011
    } chan_mode_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

endpackage : ccp_pkg

//--- verification/ccp_checker_asserts.sv
`timescale 1ns/1ps
module ccp_checker (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // pins and interrupt
    input wire logic [1:0] CH_PIN_I,
    input wire logic [1:0] CH_PIN_O,
    input wire logic [1:0] CH_PIN_OE_O,
    input wire logic IRQ_O
);
    logic [7:0] idx;
    logic wr_done;
    logic wr_mode;
    logic mapped;
    assign idx = PADDR_I[9:2];
    assign wr_done = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
    assign wr_mode = wr_done & (idx == 8'h49);
    assign mapped = (idx inside {8'h23, 8'h24, 8'h27, 8'h43, 8'h44, 8'h45, [8'h49:8'h4d]})
        && (PADDR_I[11:10] == 2'b00) && (PADDR_I[1:0] == 2'b00);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);
    chk_ready_wait: assert property (
        $rose(PENABLE_I) && PSEL_I |-> !PREADY_O ##1 PREADY_O) else $error("late pready");
    chk_ready_pulse: assert property (
        PREADY_O |-> $past(PSEL_I && PENABLE_I) ##1 !PREADY_O) else $error("pready width");
    chk_err_ready: assert property (
        PSLVERR_O |-> PREADY_O && !mapped) else $error("stray pslverr");
    chk_ok_mapped: assert property (
        PREADY_O && mapped |-> !PSLVERR_O) else $error("pslverr on mapped");
    chk_rdata_byte: assert property (
        PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0 && (mapped || PRDATA_O[7:0] == 8'h00))
        else $error("read data width");
    chk_pin_held: assert property (
        !$past(SRST_I) |-> ((CH_PIN_O ^ $past(CH_PIN_O)) & ~CH_PIN_OE_O) == 2'b00)
        else $error("undriven pin moved");
    chk_oe_by_write: assert property (
        !$past(SRST_I) && CH_PIN_OE_O != $past(CH_PIN_OE_O) |-> $past(wr_mode))
        else $error("enable moved without mode write");
    chk_start_level0: assert property (
        $past(wr_mode) && $past(PWDATA_I[3:1]) == 3'b100
        |-> CH_PIN_OE_O[0] && CH_PIN_O[0] == $past(PWDATA_I[0])) else $error("pin0 start");
    chk_start_level1: assert property (
        $past(wr_mode) && $past(PWDATA_I[7:5]) == 3'b100
        |-> CH_PIN_OE_O[1] && CH_PIN_O[1] == $past(PWDATA_I[4])) else $error("pin1 start");
    chk_irq_clear: assert property (
        $fell(IRQ_O) && !$past(SRST_I) |-> $past(wr_done)) else $error("irq dropped alone");
    cover property (PSLVERR_O);
    cover property ($rose(IRQ_O));
    cover property ($fell(CH_PIN_O[0]) && CH_PIN_OE_O[0]);
endmodule : ccp_checker

bind dual_capture_compare ccp_checker u_chk (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CH_PIN_I(CH_PIN_I), .CH_PIN_O(CH_PIN_O),
    .CH_PIN_OE_O(CH_PIN_OE_O), .IRQ_O(IRQ_O)
);

//--- verification/pin_source.sv
`timescale 1ns/1ps
module pin_source (
    // clock
    input wire logic clk_i,
    // device side of the pins
    input wire logic [1:0] dev_o_i,
    input wire logic [1:0] dev_oe_i,
    // wire level seen by the device
    output logic [1:0] pin_o
);
    logic [1:0] lvl_r = 2'b00;
    // driven pins follow the device, released ones follow the source
    assign pin_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & lvl_r);
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            @(posedge clk_i);
            lvl_r[ch] <= 1'b1;
            repeat (w) @(posedge clk_i);
            lvl_r[ch] <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
    endtask : pulse
endmodule : pin_source

//--- verification/dual_capture_compare_tb_top.sv
`timescale 1ns/1ps
module dual_capture_compare_tb_top;
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_t;
    typedef struct packed {
        logic [3:0] mode;
        logic oe;
        logic p0;
        logic p1;
        logic flag;
    } cmp_t;
    row_t rows [13] = '{
        '{1'b0, 8'h24, 8'h00, 8'h00}, '{1'b0, 8'h27, 8'h00, 8'h00},
        '{1'b0, 8'h43, 8'h00, 8'h00}, '{1'b0, 8'h49, 8'h00, 8'h00},
        '{1'b1, 8'h23, 8'h80, 8'h80}, '{1'b1, 8'h24, 8'h03, 8'h03},
        '{1'b1, 8'h43, 8'h07, 8'h04}, '{1'b1, 8'h4a, 8'h12, 8'h12},
        '{1'b1, 8'h4b, 8'h34, 8'h34}, '{1'b1, 8'h4c, 8'h56, 8'h56},
        '{1'b1, 8'h4d, 8'h78, 8'h78}, '{1'b1, 8'h44, 8'h55, 8'h00},
        '{1'b1, 8'h43, 8'h00, 8'h00}};
    cmp_t cmps [6] = '{'{4'h8, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h9, 1'b1, 1'b1, 1'b0, 1'b1},
        '{4'ha, 1'b0, 1'b0, 1'b0, 1'b1}, '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{4'h3, 1'b0, 1'b0, 1'b0, 1'b0}, '{4'hc, 1'b0, 1'b0, 1'b0, 1'b0}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, err, p;
    logic [1:0] pin, pin_o, pin_oe;
    logic [7:0] rd, a;
    int n_mismatch = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    dual_capture_compare dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CH_PIN_I(pin),
        .CH_PIN_O(pin_o), .CH_PIN_OE_O(pin_oe), .IRQ_O(irq));
    pin_source src (.clk_i(clk), .dev_o_i(pin_o), .dev_oe_i(pin_oe), .pin_o(pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rw(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : rw
    task automatic end_of_test;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) rw(1'b1, rows[i].idx, rows[i].wd);
            rw(1'b0, rows[i].idx, 8'h00);
            chk(rd, rows[i].exp);
        end
        rw(1'b0, 8'h10, 8'h00);
        chk({err, rd}, 16'h0100);
        rw(1'b1, 8'h43, 8'h84);
        rw(1'b0, 8'h45, 8'h00);
        a = rd;
        rw(1'b0, 8'h45, 8'h00);
        chk(rd - a, 16'h0004);
        rw(1'b1, 8'h43, 8'h00);
        rw(1'b0, 8'h45, 8'h00);
        chk(rd, 8'h00);
        rw(1'b1, 8'h43, 8'h84);
        rw(1'b1, 8'h49, 8'h45);
        rw(1'b1, 8'h27, 8'h00);
        // first capture value is discarded, flag only
        src.pulse(0, 1, 3);
        rw(1'b0, 8'h27, 8'h00);
        chk(rd, 8'h01);
        rw(1'b0, 8'h45, 8'h00);
        a = rd;
        src.pulse(0, 1, 3);
        rw(1'b0, 8'h4b, 8'h00);
        chk(rd > a, 1'b1);
        a = rd;
        src.pulse(0, 1, 8);
        rw(1'b0, 8'h4b, 8'h00);
        chk(rd > a, 1'b1);
        chk(irq, 1'b1);
        rw(1'b1, 8'h23, 8'h00);
        chk(irq, 1'b0);
        rw(1'b1, 8'h23, 8'h80);
        rw(1'b1, 8'h27, 8'h00);
        rw(1'b0, 8'h27, 8'h00);
        chk(rd, 8'h00);
        src.pulse(1, 1, 3);
        rw(1'b0, 8'h27, 8'h00);
        chk(rd, 8'h02);
        for (int k = 0; k < 2; k++) begin
            rw(1'b1, 8'h49, k ? 8'h07 : 8'h06);
            src.pulse(0, 2, 3);
            rw(1'b1, 8'h49, k ? 8'h07 : 8'h06);
            rw(1'b1, 8'h27, 8'h00);
            src.pulse(0, k ? 15 : 3, 3);
            rw(1'b0, 8'h27, 8'h00);
            chk(rd[0], 1'b0);
            src.pulse(0, 1, 3);
            rw(1'b0, 8'h27, 8'h00);
            chk(rd[0], 1'b1);
        end
        foreach (cmps[i]) begin
            rw(1'b1, 8'h43, 8'h00);
            rw(1'b1, 8'h4a, 8'h00);
            rw(1'b1, 8'h4b, 8'h10);
            rw(1'b1, 8'h27, 8'h00);
            rw(1'b1, 8'h49, {cmps[i].mode, cmps[i].mode});
            chk(pin_oe[0], cmps[i].oe);
            if (cmps[i].oe) chk(pin_o[0], cmps[i].p0);
            rw(1'b1, 8'h43, 8'h84);
            repeat (40) @(posedge clk);
            rw(1'b0, 8'h27, 8'h00);
            chk(rd[0], cmps[i].flag);
            if (cmps[i].oe) chk(pin_o[0], cmps[i].p1);
        end
        rw(1'b1, 8'h43, 8'h00);
        rw(1'b1, 8'h49, 8'h02);
        p = pin_o[0];
        rw(1'b1, 8'h43, 8'h80);
        repeat (100) @(posedge clk);
        chk(pin_o[0], !p);
        repeat (256) @(posedge clk);
        chk(pin_o[0], p);
        rw(1'b1, 8'h43, 8'h00);
        rw(1'b1, 8'h4c, 8'h00);
        rw(1'b1, 8'h4d, 8'h10);
        rw(1'b1, 8'h49, 8'hb0);
        rw(1'b1, 8'h27, 8'h00);
        rw(1'b1, 8'h43, 8'h84);
        repeat (100) @(posedge clk);
        rw(1'b0, 8'h45, 8'h00);
        chk(rd <= 8'h10, 1'b1);
        rw(1'b0, 8'h27, 8'h00);
        chk(rd[1], 1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rw(1'b0, 8'h49, 8'h00);
        chk({pin_oe, rd}, 16'h0000);
        end_of_test();
    end
endmodule : dual_capture_compare_tb_top
